// >>> logic/acsr_pkg.sv
// package for the converter control and serial readout block
// holds word layout, timing figures and shared types; no logic
package acsr_pkg;

  // ------------------------------------------------------------------
  // result word layout
  // ------------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CODE_BITS = 22;
  localparam int OVH_POS = 22;
  localparam int OVL_POS = 23;
  localparam int SIGN_POS = 21;
  localparam logic [4:0] WORD_BITS_5 = 5'h18;
  localparam logic [4:0] LAST_FALL_CNT = 5'h18;
  localparam logic [4:0] BIT_CNT_IDLE = 5'h00;
  localparam logic [4:0] BIT_CNT_FIRST = 5'h01;
  // sample limits in lsb units: +ref-1lsb and -ref
  localparam logic signed [23:0] CODE_POS_LIMIT = 24'sh1F_FFFF;
  localparam logic signed [23:0] CODE_NEG_LIMIT = 24'shE0_0000;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PWRUP_TIME_US = 300;
  localparam int PWRUP_CYCLES_DEF = (PWRUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_TICKS = 32;
  localparam int CONV_TICKS_DEF = 1024;
  localparam int FIFO_DEPTH = 8;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic overflow_low_flag;
    logic overflow_high_flag;
    logic [CODE_BITS-1:0] code;
  } acsr_word_s;

  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_SETTLE,
    ST_CONVERT,
    ST_SLEEP
  } acsr_state_e;

endpackage : acsr_pkg

// >>> logic/acsr_fifo.sv
// flip-flop fifo with valid/ready on both sides and a synchronous flush
// assumes one clock domain; flush wins over a push in the same cycle
`timescale 1ns/1ps
`default_nettype none
module acsr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset; entries are only read once written
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk) begin
        if (push && wr_ptr_reg == AW'(gi)) mem_reg[gi] <= in_data;
      end
    end
  endgenerate

endmodule : acsr_fifo
`default_nettype wire

// >>> logic/acsr_top.sv
// conversion control and three-wire serial readout of a 22-bit converter
// chip select and serial clock come from the host and are resynchronised;
// the filter result arrives as a signed sample on SAMPLE_CODE.
//
// Notes on behaviour
// - result word is 24 bits, 22 data
// - line high converting, low when ready
// - line released while chip select high
// - bit 22 set above reference minus lsb
// - bit 23 set below negative reference
// - bits 21..0 two's complement, bit 21 sign
// - chip select fall in shutdown starts conversion
// - rise mid-conversion: finish, then single mode
// - later fall in same conversion starts nothing
// - single result read low, lost on rise
// - single mode: line high after 25th clock
// - single mode: busy latched at select fall
// - continuous: results queue in the fifo during a transfer, else replace the buffer; a full fifo stalls conversion
// - buffer frozen until all 24 bits out
// - rise never shortens; discards all data
// - ready indication waits for transfer end
// - lsb held until 25th falling clock
// - continuous ready updates dynamically
// - select held low: continuous, 300 us start
// - wait 32 oscillator periods before converting
`timescale 1ns/1ps
`default_nettype none
module acsr_top
  import acsr_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYCLES_DEF,
  parameter int CONV_TICKS = CONV_TICKS_DEF
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CHIP_SELECT_LOW_ACTIVE_N,
  input wire logic SCK,
  input wire logic signed [WORD_BITS-1:0] SAMPLE_CODE,
  output logic DATA_OUT_READY_LINE_O,
  output logic DATA_OUT_READY_LINE_OE_N,
  output logic BUSY,
  output logic SHUTDOWN,
  output logic SINGLE_MODE,
  output logic DATA_READY
);

  // ------------------------------------------------------------------
  // internal oscillator model
  // ------------------------------------------------------------------
  // one oscillator period spans the power-up wait divided by its ticks,
  // so the 32-tick settle lands on the 300 us figure
  localparam int OSC_DIV = (PWRUP_CYCLES + SETTLE_TICKS - 1) / SETTLE_TICKS;
  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
  localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_TICKS - 1);
  localparam logic [23:0] CONV_LAST = 24'(CONV_TICKS - 1);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic cs_q1_reg, cs_q2_reg, cs_q3_reg, cs_lvl_reg;
  logic sck_q1_reg, sck_q2_reg, sck_q3_reg, sck_lvl_reg;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_q1_reg <= 1'b1;
      cs_q2_reg <= 1'b1;
      cs_q3_reg <= 1'b1;
      cs_lvl_reg <= 1'b1;
      // reset at the low level so an idle-low clock gives no false fall
      sck_q1_reg <= 1'b0;
      sck_q2_reg <= 1'b0;
      sck_q3_reg <= 1'b0;
      sck_lvl_reg <= 1'b0;
    end else begin
      cs_q1_reg <= CHIP_SELECT_LOW_ACTIVE_N;
      cs_q2_reg <= cs_q1_reg;
      cs_q3_reg <= cs_q2_reg;
      cs_lvl_reg <= (cs_q2_reg == cs_q3_reg) ? cs_q3_reg : cs_lvl_reg;
      sck_q1_reg <= SCK;
      sck_q2_reg <= sck_q1_reg;
      sck_q3_reg <= sck_q2_reg;
      sck_lvl_reg <= (sck_q2_reg == sck_q3_reg) ? sck_q3_reg : sck_lvl_reg;
    end
  end

  wire logic cs_agree = (cs_q2_reg == cs_q3_reg);
  wire logic cs_fall = cs_agree & cs_lvl_reg & ~cs_q3_reg;
  wire logic cs_rise = cs_agree & ~cs_lvl_reg & cs_q3_reg;
  wire logic sck_agree = (sck_q2_reg == sck_q3_reg);
  wire logic sck_fall = sck_agree & sck_lvl_reg & ~sck_q3_reg;
  wire logic selected = ~cs_lvl_reg;

  // ------------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------------
  acsr_state_e state_reg, state_next;
  logic [15:0] osc_cnt_reg;
  logic [5:0] settle_cnt_reg;
  logic [23:0] conv_cnt_reg;
  logic single_reg;

  wire logic osc_tick = (osc_cnt_reg == OSC_LAST);
  wire logic in_settle = (state_reg == ST_SETTLE);
  wire logic in_convert = (state_reg == ST_CONVERT);
  wire logic settle_done = in_settle & osc_tick & (settle_cnt_reg == SETTLE_LAST);
  wire logic conv_end = in_convert & osc_tick & (conv_cnt_reg == CONV_LAST);
  // a single conversion that ends with select high has nobody to read it
  wire logic keep_result = ~(single_reg & cs_lvl_reg);
  logic fifo_in_ready;
  wire logic fifo_push = conv_end & keep_result;
  // a full fifo stalls the final tick, so a full fifo never drops a result
  wire logic conv_finish = conv_end & (fifo_in_ready | ~keep_result);
  wire logic start_conv = (state_reg == ST_SHUTDOWN) & selected;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUTDOWN: if (start_conv) state_next = ST_SETTLE;
      ST_SETTLE: if (settle_done) state_next = ST_CONVERT;
      ST_CONVERT: begin
        // a rise only marks single mode; the conversion still runs out
        if (conv_finish) begin
          if (!single_reg) state_next = ST_CONVERT;
          else if (selected) state_next = ST_SLEEP;
          else state_next = ST_SHUTDOWN;
        end
      end
      ST_SLEEP: if (cs_rise) state_next = ST_SHUTDOWN;
      default: state_next = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_SHUTDOWN;
      single_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_conv) single_reg <= 1'b0;
      else if (cs_rise && (in_settle || in_convert)) single_reg <= 1'b1;
    end
  end

  // oscillator held in reset during shutdown and sleep
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_cnt_reg <= '0;
      settle_cnt_reg <= '0;
      conv_cnt_reg <= '0;
    end else begin
      if (!(in_settle || in_convert) || osc_tick) osc_cnt_reg <= '0;
      else osc_cnt_reg <= osc_cnt_reg + 16'h0001;
      if (!in_settle) settle_cnt_reg <= '0;
      else if (osc_tick) settle_cnt_reg <= settle_cnt_reg + 6'h01;
      if (!in_convert || conv_finish) conv_cnt_reg <= '0;
      else if (osc_tick && !conv_end) conv_cnt_reg <= conv_cnt_reg + 24'h00_0001;
    end
  end

  // ------------------------------------------------------------------
  // result formatting
  // ------------------------------------------------------------------
  acsr_word_s fmt_word;
  assign fmt_word.overflow_high_flag = (SAMPLE_CODE > CODE_POS_LIMIT);
  assign fmt_word.overflow_low_flag = (SAMPLE_CODE < CODE_NEG_LIMIT);
  // no saturation: low 22 bits pass as is, sample bit 21 stays the sign
  assign fmt_word.code = SAMPLE_CODE[CODE_BITS-1:0];

  // ------------------------------------------------------------------
  // result fifo and output buffer
  // ------------------------------------------------------------------
  logic [4:0] bit_cnt_reg;
  acsr_word_s out_word_reg;
  acsr_word_s fifo_word;
  logic buf_ready_reg;
  logic fifo_out_valid;
  logic rdy_latch_reg;

  wire logic shifting = (bit_cnt_reg != BIT_CNT_IDLE);
  wire logic shift_start = sck_fall & selected & buf_ready_reg & ~shifting;
  wire logic shift_step = sck_fall & selected & shifting;
  wire logic shift_last = shift_step & (bit_cnt_reg == LAST_FALL_CNT);
  // the buffer reloads only between transfers, and always from the oldest queued result
  wire logic fifo_out_ready = ~shifting & ~shift_start & ~cs_rise;
  wire logic buf_load = fifo_out_valid & fifo_out_ready;

  acsr_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .flush(cs_rise),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fmt_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_word)
  );

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_word_reg <= '0;
      buf_ready_reg <= 1'b0;
    end else if (cs_rise) begin
      out_word_reg <= '0;
      buf_ready_reg <= 1'b0;
    end else if (shift_last) begin
      buf_ready_reg <= 1'b0;
    end else if (buf_load) begin
      out_word_reg <= fifo_word;
      buf_ready_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // serial shifter
  // ------------------------------------------------------------------
  // falls 1..24 put bit 23..0 out; fall 25 ends the transfer
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_reg <= BIT_CNT_IDLE;
    end else if (cs_rise || shift_last) begin
      bit_cnt_reg <= BIT_CNT_IDLE;
    end else if (shift_start || shift_step) begin
      bit_cnt_reg <= bit_cnt_reg + BIT_CNT_FIRST;
    end
  end

  // single mode shows the busy state seen at the select fall
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdy_latch_reg <= 1'b1;
    end else if (cs_fall) begin
      rdy_latch_reg <= ~buf_ready_reg;
    end else if (shift_last) begin
      rdy_latch_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------------
  logic [4:0] bit_idx;
  logic line_next;
  logic oe_n_next;
  logic cur_bit;
  logic shift_vis;
  logic single_next;

  assign bit_idx = WORD_BITS_5 - bit_cnt_next_view();
  assign cur_bit = out_word_reg[bit_idx];

  function automatic logic [4:0] bit_cnt_next_view();
    logic [4:0] v;
    v = bit_cnt_reg;
    if (shift_start || shift_step) v = bit_cnt_reg + BIT_CNT_FIRST;
    if (shift_last || cs_rise) v = BIT_CNT_IDLE;
    return v;
  endfunction : bit_cnt_next_view

  assign shift_vis = (bit_cnt_next_view() != BIT_CNT_IDLE);
  assign single_next = start_conv ? 1'b0 :
                       ((cs_rise && (in_settle || in_convert)) ? 1'b1 : single_reg);

  always_comb begin
    oe_n_next = cs_q3_reg | ~cs_agree ? cs_lvl_reg | cs_rise : 1'b0;
    if (cs_rise) oe_n_next = 1'b1;
    else if (cs_fall) oe_n_next = 1'b0;
    else oe_n_next = cs_lvl_reg;
    if (shift_vis) line_next = cur_bit;
    else if (single_next) line_next = cs_fall ? ~buf_ready_reg :
                                      (shift_last ? 1'b1 : rdy_latch_reg);
    else if (shift_last) line_next = 1'b1;
    else line_next = ~(buf_ready_reg | buf_load);
    if (oe_n_next) line_next = 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_OUT_READY_LINE_O <= 1'b0;
      DATA_OUT_READY_LINE_OE_N <= 1'b1;
      BUSY <= 1'b0;
      SHUTDOWN <= 1'b1;
      SINGLE_MODE <= 1'b0;
      DATA_READY <= 1'b0;
    end else begin
      DATA_OUT_READY_LINE_O <= line_next;
      DATA_OUT_READY_LINE_OE_N <= oe_n_next;
      BUSY <= (state_next == ST_SETTLE) || (state_next == ST_CONVERT);
      SHUTDOWN <= (state_next == ST_SHUTDOWN);
      SINGLE_MODE <= single_next;
      DATA_READY <= buf_ready_reg;
    end
  end

endmodule : acsr_top
`default_nettype wire

// >>> tb/acsr_monitor.sv
// checker for acsr_top, sees only its ports
// bound from tb_top; one clock domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module acsr_monitor
  import acsr_pkg::*;
#(
  parameter int PWRUP_CYCLES = 64,
  parameter int CONV_TICKS = 8
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CHIP_SELECT_LOW_ACTIVE_N,
  input wire logic SCK,
  input wire logic signed [WORD_BITS-1:0] SAMPLE_CODE,
  input wire logic DATA_OUT_READY_LINE_O,
  input wire logic DATA_OUT_READY_LINE_OE_N,
  input wire logic BUSY,
  input wire logic SHUTDOWN,
  input wire logic SINGLE_MODE,
  input wire logic DATA_READY
);
  wire chip_select_low_active = CHIP_SELECT_LOW_ACTIVE_N;
  wire oe_n = DATA_OUT_READY_LINE_OE_N;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // seven samples cover the three-flop synchroniser plus the output flop
  chk_release_select_high: assert property (chip_select_low_active [*7] |-> oe_n)
    else $error("line driven with select high");
  chk_drive_select_low: assert property (!chip_select_low_active [*7] |-> !oe_n)
    else $error("line released with select low");
  chk_shutdown_empty: assert property (SHUTDOWN && $past(SHUTDOWN) |-> !DATA_READY)
    else $error("data kept in shutdown");
  chk_busy_not_shut: assert property (BUSY |-> !SHUTDOWN)
    else $error("busy while in shutdown");
  chk_single_only_conv: assert property ($rose(SINGLE_MODE) |-> $past(BUSY))
    else $error("single mode set outside conversion");
  chk_single_no_restart: assert property ($fell(BUSY) && SINGLE_MODE |-> ##1 !BUSY [*4])
    else $error("conversion restarted in single mode");
  chk_fall_starts_conv: assert property (SHUTDOWN && $fell(chip_select_low_active) |-> ##[1:8] BUSY)
    else $error("select fall did not start conversion");
  chk_rise_discards: assert property ($rose(chip_select_low_active) |-> ##6 !DATA_READY)
    else $error("data kept after select rise");
  cover property ($rose(SINGLE_MODE));
  cover property ($fell(oe_n));
  cover property ($fell(BUSY) && !chip_select_low_active);
endmodule : acsr_monitor
`default_nettype wire

// >>> tb/acsr_host.sv
// host spi port model: drives select and a 320 ns serial clock, idle low
// assumes the caller enters tasks just after a rising sys clock edge
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
  input wire logic clk,
  input wire logic line,
  input wire logic oe_n,
  output logic cs_n,
  output logic sck
);
  logic last;
  // a released line has no pull: read it as the inverse of the last level
  wire rx = oe_n ? ~last : line;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    last = 1'b0;
  end
  always @(posedge clk) if (!oe_n) last <= line;
  task automatic sel(input logic v);
    cs_n <= v;
    repeat (8) @(posedge clk);
  endtask : sel
  // first high phase shows ready, then bits 23 down to 0 after each fall
  task automatic xfer(input int n, input int gap, output logic [24:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b1;
      repeat (3) @(posedge clk);
      // sampled late in the high phase: the pin passes a synchroniser
      w = {w[23:0], rx};
      if (i == 12) repeat (gap) @(posedge clk);
      @(posedge clk);
      sck <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : xfer
endmodule : acsr_host
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for acsr_top with a host model on the serial side
// short power-up wait and conversion counts; conversion time is measured
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acsr_pkg::*;
  logic sys_clk;
  logic arst_n;
  logic signed [23:0] sample_code;
  wire cs_n, sck, line_o, oe_n, busy, shutdown, single_mode, data_ready;
  int errors = 0;
  int num_checks = 0;
  int conv_cyc;
  int n;
  logic [24:0] w;
  logic signed [23:0] codes [5] = '{24'sh1F_FFFF, 24'sh20_0000, 24'shFF_FFFF,
    24'shE0_0000, 24'shDF_FFFF};
  logic [23:0] words [5] = '{24'h1F_FFFF, 24'h60_0000, 24'h3F_FFFF, 24'h20_0000,
    24'h9F_FFFF};
  always #20 sys_clk = ~sys_clk;
  acsr_top #(.PWRUP_CYCLES(64), .CONV_TICKS(8)) dut (.SYS_CLK(sys_clk), .ARST_N(arst_n),
    .CHIP_SELECT_LOW_ACTIVE_N(cs_n), .SCK(sck), .SAMPLE_CODE(sample_code),
    .DATA_OUT_READY_LINE_O(line_o), .DATA_OUT_READY_LINE_OE_N(oe_n), .BUSY(busy),
    .SHUTDOWN(shutdown), .SINGLE_MODE(single_mode), .DATA_READY(data_ready));
  acsr_host host (.clk(sys_clk), .line(line_o), .oe_n(oe_n), .cs_n(cs_n), .sck(sck));
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // b selects the wait: 1 for busy low, 0 for the line showing ready
  task automatic wait_low(input logic b, output int c);
    c = 0;
    while ((b ? busy : (line_o | oe_n)) !== 1'b0) begin
      @(posedge sys_clk);
      c++;
      if (c > 20000) begin
        check("wait bound", 0, 1);
        conclude();
      end
    end
  endtask : wait_low
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    sample_code = 24'sh00_0000;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("oe idle", 1, oe_n);
    check("shutdown", 1, shutdown);
    sample_code <= 24'sh12_3456;
    host.sel(1'b0);
    check("busy line", 2'b01, {oe_n, line_o});
    host.sel(1'b1);
    check("single", 1, single_mode);
    host.sel(1'b0);
    wait_low(1'b1, conv_cyc);
    repeat (6) @(posedge sys_clk);
    check("sleep", 3'b001, {busy, shutdown, line_o});
    host.xfer(25, 0, w);
    check("single word", {1'b1, 24'h12_3456}, w);
    repeat (6) @(posedge sys_clk);
    check("after 25", 1, line_o);
    host.sel(1'b1);
    check("discard", 2'b10, {shutdown, data_ready});
    for (int i = 0; i < 5; i++) begin
      sample_code <= codes[i];
      host.sel(1'b0);
      wait_low(1'b0, n);
      host.xfer(25, 0, w);
      check("word", {1'b0, words[i]}, w);
      check("flag pair", 0, &w[23:22]);
      if (i < 4) host.sel(1'b1);
      if (i < 4) wait_low(1'b1, n);
    end
    sample_code <= 24'sh0A_BCDE;
    repeat (2 * conv_cyc) @(posedge sys_clk);
    wait_low(1'b0, n);
    fork
      host.xfer(25, 2 * conv_cyc, w);
      begin
        repeat (40) @(posedge sys_clk);
        sample_code <= 24'sh01_2345;
      end
    join
    check("frozen word", {1'b0, 24'h0A_BCDE}, w);
    repeat (6) @(posedge sys_clk);
    check("ready after", 0, line_o);
    host.xfer(25, 0, w);
    check("newest word", {1'b0, 24'h01_2345}, w);
    host.xfer(10, 0, w);
    host.sel(1'b1);
    check("abort oe", 1, oe_n);
    wait_low(1'b1, n);
    repeat (8) @(posedge sys_clk);
    check("abort lost", 0, data_ready);
    host.sel(1'b0);
    check("restart", 1, busy);
    arst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    wait_low(1'b0, n);
    host.xfer(25, 0, w);
    check("powerup word", {1'b0, 24'h01_2345}, w);
    conclude();
  end
endmodule : tb_top
bind acsr_top acsr_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES), .CONV_TICKS(CONV_TICKS)) mon (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CHIP_SELECT_LOW_ACTIVE_N(CHIP_SELECT_LOW_ACTIVE_N),
  .SCK(SCK), .SAMPLE_CODE(SAMPLE_CODE), .DATA_OUT_READY_LINE_O(DATA_OUT_READY_LINE_O),
  .DATA_OUT_READY_LINE_OE_N(DATA_OUT_READY_LINE_OE_N), .BUSY(BUSY), .SHUTDOWN(SHUTDOWN),
  .SINGLE_MODE(SINGLE_MODE), .DATA_READY(DATA_READY));
`default_nettype wire
